// >>> strap_defs.svh
// Offsets, field positions, reset values and timing counts for the external-port strap loader.
`ifndef STRAP_DEFS_SVH
`define STRAP_DEFS_SVH
`define OFF_STRAP_CTRL 12'h000
`define OFF_STRAP_STATUS 12'h004
`define OFF_FLOW_CTRL 12'h008
`define OFF_PARTNER 12'h00c
`define OFF_ADVERT 12'h010
`define OFF_SPECIAL 12'h014
`define OFF_OVERRIDE 12'h018
`define FC_BACKPRESSURE 0
`define FC_TX_PAUSE 1
`define FC_RX_PAUSE 2
`define FC_MANUAL 3
`define LP_PAUSE 10
`define LP_ASYM 11
`define LP_10H 5
`define LP_10F 6
`define LP_100H 7
`define LP_100F 8
`define ADV_PAUSE 10
`define ADV_ASYM 11
`define SC_HEARTBEAT 11
`define DEF_BACKPRESSURE 1'b1
`define DEF_FULLDUPLEX_FC 1'b1
`define DEF_MANUAL_PAUSE 1'b0
`define DEF_HEARTBEAT_OFF 1'b0
`define DEF_DUPLEX_POL 1'b0
`define SETTLE_NS 64
`define SETTLE_CYCLES ((`SETTLE_NS + 7) / 8)
`endif

// >>> strap_pkg.sv
// Types shared by the strap loader modules.
package strap_pkg;
  // Operating mode of the external port.
  typedef enum logic [1:0] {
    MODE_MII_MAC = 2'h0,
    MODE_MII_PHY = 2'h1,
    MODE_RMII_PHY = 2'h2,
    MODE_RESERVED = 2'h3
  } port_mode_t;
  // Loader sequence states.
  typedef enum logic [2:0] {
    ST_SETTLE = 3'h1,
    ST_APPLY = 3'h2,
    ST_RUN = 3'h4
  } load_state_t;
endpackage

// >>> strap_if.sv
// Interface carrying synchronised strap levels between the sampler and the loader.
`timescale 1ns/100ps
`default_nettype none
interface strap_if;
  // Synchronised straps, in the order backpressure, fc, manual, heartbeat, polarity.
  logic [4:0] level;
  // Synchronised duplex indication pin.
  logic duplex;
  modport sampler (output level, output duplex);
  modport loader (input level, input duplex);
endinterface
`default_nettype wire

// >>> strap_sync.sv
// Two-flop synchroniser for strap pins and the duplex indication pin.
`timescale 1ns/100ps
`default_nettype none
module strap_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] pins,
  strap_if.sampler out
);
  // First and second synchroniser stages.
  logic [5:0] stage1;
  logic [5:0] stage2;
  // Stage one is only read by stage two.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 6'h00;
      stage2 <= 6'h00;
    end else begin
      stage1 <= pins;
      stage2 <= stage1;
    end
  end
  assign out.level = stage2[4:0];
  assign out.duplex = stage2[5];
endmodule // strap_sync
`default_nettype wire

// >>> port0_strap_defaults.sv
// External-port soft-strap loader with an APB register view of the resulting defaults.
// How it works
// RQ1: Polarity strap decides full-duplex level in MAC.
// RQ2: Polarity strap sets partner speed/duplex abilities.
// RQ3: Backpressure enable loads from strap, default one.
// RQ4: Tx and rx pause load from fc strap.
// RQ5: Fc strap sets partner pause bits.
// RQ6: Manual strap sets select and advertised pause.
// RQ7: MAC mode ignores manual strap; host decides.
// RQ8: Heartbeat-off loads only in MII PHY mode.
// RQ9: Loader-supplied values may replace strap values.
// RQ10: Sample at reset, hold until software writes.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "strap_defs.svh"
module port0_strap_defaults
  import strap_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_backpressure_default_sel,
  input wire logic ext_fullduplex_fc_default_sel,
  input wire logic ext_manual_pause_default_sel,
  input wire logic heartbeat_off_default_sel,
  input wire logic duplex_pol_default_sel,
  input wire logic ext_port_duplex_pin,
  input wire logic [1:0] port_mode,
  output logic ext_backpressure_enable,
  output logic ext_tx_pause_enable,
  output logic ext_rx_pause_enable,
  output logic ext_manual_pause_select,
  output logic heartbeat_off,
  output logic ext_full_duplex,
  output logic defaults_loaded
);
  // Synchronised strap levels.
  strap_if straps ();
  strap_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins({ext_port_duplex_pin, duplex_pol_default_sel, heartbeat_off_default_sel,
           ext_manual_pause_default_sel, ext_fullduplex_fc_default_sel,
           ext_backpressure_default_sel}),
    .out(straps)
  );
  // Mode after synchronising, since it is a pin level too.
  logic [1:0] mode_s1;
  logic [1:0] mode_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_s1 <= 2'h0;
      mode_s2 <= 2'h0;
    end else begin
      mode_s1 <= port_mode;
      mode_s2 <= mode_s1;
    end
  end
  port_mode_t mode;
  assign mode = port_mode_t'(mode_s2);
  // Loader state, settle counter, latched straps and register contents.
  load_state_t state, next_state;
  logic [3:0] settle, next_settle;
  logic [4:0] latched, next_latched;
  logic [4:0] override_val, next_override_val;
  logic override_en, next_override_en;
  logic [3:0] flow, next_flow;
  logic [15:0] partner, next_partner;
  logic [15:0] advert, next_advert;
  logic [15:0] special, next_special;
  logic full_dup, next_full_dup;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  // Effective strap set: loader override or pins.
  logic [4:0] eff;
  logic wr_take, rd_take;
  // A write lands only at the edge that sees pready high, as the master completes it then.
  assign wr_take = psel && penable && pwrite && pready;
  assign rd_take = psel && !penable && !pwrite;
  // Next-value logic for the sequencer, registers and bus slave.
  always_comb begin
    next_state = state;
    next_settle = settle;
    next_latched = latched;
    next_override_val = override_val;
    next_override_en = override_en;
    next_flow = flow;
    next_partner = partner;
    next_advert = advert;
    next_special = special;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    // RQ9: loader values win
    eff = override_en ? override_val : straps.level;
    // RQ1: polarity picks full level
    next_full_dup = (mode == MODE_MII_MAC) ? (straps.duplex ^ latched[4]) : full_dup;
    unique case (state)
      ST_SETTLE: begin
        // RQ10: sample after reset
        next_latched = eff;
        if (settle == 4'(`SETTLE_CYCLES)) begin
          next_state = ST_APPLY;
        end else begin
          next_settle = settle + 4'h1;
        end
      end
      ST_APPLY: begin
        // RQ3: backpressure default
        next_flow[`FC_BACKPRESSURE] = latched[0];
        // RQ4: tx/rx pause default
        next_flow[`FC_TX_PAUSE] = latched[1];
        next_flow[`FC_RX_PAUSE] = latched[1];
        // RQ7: MAC mode ignores manual strap
        // RQ6: manual select default
        next_flow[`FC_MANUAL] = (mode == MODE_MII_MAC) ? `DEF_MANUAL_PAUSE : latched[2];
        next_advert = 16'h0000;
        next_advert[`ADV_PAUSE] = (mode != MODE_MII_MAC) && latched[2];
        next_advert[`ADV_ASYM] = (mode != MODE_MII_MAC) && latched[2];
        next_partner = 16'h0000;
        // RQ5: partner pause bits
        next_partner[`LP_PAUSE] = latched[1];
        next_partner[`LP_ASYM] = latched[1];
        // RQ2: partner abilities from polarity
        next_partner[`LP_100F] = !latched[4];
        next_partner[`LP_10F] = !latched[4];
        next_partner[`LP_100H] = latched[4];
        next_partner[`LP_10H] = latched[4];
        next_special = 16'h0000;
        // RQ8: only in MII PHY mode
        next_special[`SC_HEARTBEAT] = (mode == MODE_MII_PHY) ? latched[3] : `DEF_HEARTBEAT_OFF;
        next_state = ST_RUN;
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_SETTLE;
      end
    endcase
    // APB answers one cycle into the access phase; writes land when pready is seen.
    if (psel && penable && !pready) begin
      next_pready = 1'b1;
    end
    if (rd_take) begin
      unique case (paddr)
        `OFF_STRAP_CTRL: next_prdata = {26'h0, override_en, override_val};
        `OFF_STRAP_STATUS: next_prdata = {27'h0, latched};
        `OFF_FLOW_CTRL: next_prdata = {28'h0, flow};
        `OFF_PARTNER: next_prdata = {16'h0, partner};
        `OFF_ADVERT: next_prdata = {16'h0, advert};
        `OFF_SPECIAL: next_prdata = {16'h0, special};
        `OFF_OVERRIDE: next_prdata = {30'h0, mode_s2};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && !pready) begin
      unique case (paddr)
        `OFF_STRAP_CTRL, `OFF_STRAP_STATUS, `OFF_FLOW_CTRL, `OFF_PARTNER,
        `OFF_ADVERT, `OFF_SPECIAL, `OFF_OVERRIDE: next_pslverr = 1'b0;
        default: next_pslverr = 1'b1;
      endcase
    end
    if (wr_take && (state == ST_RUN)) begin
      // RQ10: software writes replace defaults
      unique case (paddr)
        `OFF_FLOW_CTRL: next_flow = pwdata[3:0];
        `OFF_PARTNER: next_partner = pwdata[15:0];
        `OFF_ADVERT: next_advert = pwdata[15:0];
        `OFF_SPECIAL: next_special = pwdata[15:0];
        default: next_flow = next_flow;
      endcase
    end
    if (wr_take && (paddr == `OFF_STRAP_CTRL)) begin
      // RQ9: loader override, reapplied
      next_override_val = pwdata[4:0];
      next_override_en = pwdata[5];
      if (pwdata[6]) begin
        next_state = ST_SETTLE;
        next_settle = 4'h0;
      end
    end
  end
  // Registers only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_SETTLE;
      settle <= 4'h0;
      latched <= {`DEF_DUPLEX_POL, `DEF_HEARTBEAT_OFF, `DEF_MANUAL_PAUSE,
                  `DEF_FULLDUPLEX_FC, `DEF_BACKPRESSURE};
      override_val <= 5'h00;
      override_en <= 1'b0;
      flow <= 4'h0;
      partner <= 16'h0000;
      advert <= 16'h0000;
      special <= 16'h0000;
      full_dup <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ext_backpressure_enable <= 1'b0;
      ext_tx_pause_enable <= 1'b0;
      ext_rx_pause_enable <= 1'b0;
      ext_manual_pause_select <= 1'b0;
      heartbeat_off <= 1'b0;
      ext_full_duplex <= 1'b0;
      defaults_loaded <= 1'b0;
    end else begin
      state <= next_state;
      settle <= next_settle;
      latched <= next_latched;
      override_val <= next_override_val;
      override_en <= next_override_en;
      flow <= next_flow;
      partner <= next_partner;
      advert <= next_advert;
      special <= next_special;
      full_dup <= next_full_dup;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      ext_backpressure_enable <= next_flow[`FC_BACKPRESSURE];
      ext_tx_pause_enable <= next_flow[`FC_TX_PAUSE];
      ext_rx_pause_enable <= next_flow[`FC_RX_PAUSE];
      ext_manual_pause_select <= next_flow[`FC_MANUAL];
      heartbeat_off <= next_special[`SC_HEARTBEAT];
      ext_full_duplex <= next_full_dup;
      defaults_loaded <= (next_state == ST_RUN);
    end
  end
  // RQ4: tx and rx load together
  a_pause_pair: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    state == ST_APPLY |=> ext_tx_pause_enable == $past(latched[1]) &&
    ext_rx_pause_enable == $past(latched[1])) else $error("Pause enables differ.");
  // RQ3: backpressure follows strap
  a_bp_loaded: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    state == ST_APPLY |=> flow[`FC_BACKPRESSURE] == $past(latched[0])) else $error("Backpressure.");
  // RQ5: partner pause from fc
  a_lp_pause: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    state == ST_APPLY |=> partner[`LP_PAUSE] == $past(latched[1])) else $error("Partner pause.");
  // RQ2: partner duplex abilities
  a_lp_duplex: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    state == ST_APPLY |=> partner[`LP_10F] != partner[`LP_10H]) else $error("Partner duplex.");
  // RQ6: advert from manual strap
  a_adv_manual: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    state == ST_APPLY && mode != MODE_MII_MAC |=> advert[`ADV_ASYM] == $past(latched[2]))
    else $error("Advert pause.");
  // RQ7: MAC ignores manual strap
  a_mac_manual: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    state == ST_APPLY && mode == MODE_MII_MAC |=> !flow[`FC_MANUAL]) else $error("MAC manual.");
  // RQ8: heartbeat only in PHY
  a_sqe_mode: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    state == ST_APPLY && mode != MODE_MII_PHY |=> !special[`SC_HEARTBEAT]) else $error("Heartbeat.");
  // RQ10: loading ends in run
  a_load_done: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    $rose(state == ST_APPLY) |=> state == ST_RUN ##1 defaults_loaded) else $error("Load.");
  // RQ1: MAC duplex decode
  a_dup_pol: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    mode == MODE_MII_MAC |=> full_dup == ($past(straps.duplex) ^ $past(latched[4])))
    else $error("Duplex polarity.");
  c_load: cover property (@(posedge pclk) disable iff (!presetn) state == ST_APPLY);
  c_override: cover property (@(posedge pclk) disable iff (!presetn) override_en && state == ST_RUN);
  c_phy: cover property (@(posedge pclk) disable iff (!presetn) heartbeat_off);
endmodule // port0_strap_defaults
`default_nettype wire

// >>> strap_board.sv
// Board-side model of the external-port strap pins and the duplex indication input.
`timescale 1ns/100ps
`default_nettype none
`include "strap_defs.svh"
module strap_board (
  input wire logic drive_en,
  input wire logic [4:0] level,
  input wire logic duplex_in,
  output logic [4:0] strap,
  output logic duplex_pin
);
  // Undriven straps settle to their pull levels; driven ones follow the bench.
  // strap pull defaults
  assign strap = drive_en ? level : {`DEF_DUPLEX_POL, `DEF_HEARTBEAT_OFF, `DEF_MANUAL_PAUSE,
    `DEF_FULLDUPLEX_FC, `DEF_BACKPRESSURE};
  // The external device reports its duplex state on this pin.
  assign duplex_pin = duplex_in;
endmodule // strap_board
`default_nettype wire

// >>> port0_strap_defaults_bench.sv
// Self-checking bench for the external-port strap loader.
`timescale 1ns/100ps
`default_nettype none
`include "strap_defs.svh"
module port0_strap_defaults_bench;
  import strap_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, drive_en, dpx, duplex_pin, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] lvl, strap;
  logic [1:0] mode;
  wire [6:0] outs;
  int err_total, samples_checked;
  // Each entry is strap levels then port mode.
  logic [6:0] cases [6] = '{7'h7d, 7'h01, 7'h2a, 7'h74, 7'h59, 7'h6e};
  strap_board i_board (.drive_en(drive_en), .level(lvl), .duplex_in(dpx), .strap(strap),
    .duplex_pin(duplex_pin));
  port0_strap_defaults i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_backpressure_default_sel(strap[0]),
    .ext_fullduplex_fc_default_sel(strap[1]), .ext_manual_pause_default_sel(strap[2]),
    .heartbeat_off_default_sel(strap[3]), .duplex_pol_default_sel(strap[4]),
    .ext_port_duplex_pin(duplex_pin), .port_mode(mode), .ext_backpressure_enable(outs[0]),
    .ext_tx_pause_enable(outs[1]), .ext_rx_pause_enable(outs[2]),
    .ext_manual_pause_select(outs[3]), .heartbeat_off(outs[4]), .ext_full_duplex(outs[5]),
    .defaults_loaded(outs[6]));
  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Compares one result and counts it.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error flag land in rd and rerr.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The request is held until pready is seen at a rising edge.
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      tally_and_finish();
    end
    // Read data and the error flag are taken at the edge that sees pready high.
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Pulses reset and waits, bounded, for the defaults to be applied.
  task automatic restart();
    int n;
    n = 0;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    do begin
      @(negedge pclk);
      n++;
    end while (outs[6] !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  // Applies straps and mode, resets, and checks outputs and register views.
  task automatic run_case(input logic [4:0] c, input logic [1:0] m);
    logic [31:0] f;
    logic hb;
    f = {28'h0, (m != MODE_MII_MAC) & c[2], c[1], c[1], c[0]};
    hb = (m == MODE_MII_PHY) & c[3];
    lvl <= c;
    mode <= m;
    restart();
    check({27'h0, outs[4:0]}, {27'h0, hb, f[3:0]});
    apb(1'b0, `OFF_FLOW_CTRL, 32'h0);
    check(rd, f);
    if (m != MODE_MII_MAC) begin
      apb(1'b0, `OFF_PARTNER, 32'h0);
      check(rd, {20'h0, c[1], c[1], 1'b0, !c[4], c[4], !c[4], c[4], 5'h0});
      apb(1'b0, `OFF_ADVERT, 32'h0);
      check(rd, {20'h0, c[2], c[2], 10'h0});
      apb(1'b0, `OFF_SPECIAL, 32'h0);
      check(rd, {20'h0, hb, 11'h0});
    end else begin
      // Both pin levels, read through the polarity strap.
      for (int p = 0; p < 2; p++) begin
        dpx <= p[0];
        repeat (4) @(posedge pclk);
        check({31'h0, outs[5]}, {31'h0, p[0] ^ c[4]});
      end
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    drive_en = 1'b0;
    lvl = 5'h00;
    dpx = 1'b0;
    mode = MODE_MII_PHY;
    err_total = 0;
    samples_checked = 0;
    run_case(5'h03, MODE_MII_PHY);
    $display("undriven straps test done");
    drive_en <= 1'b1;
    foreach (cases[i]) begin
      run_case(cases[i][6:2], cases[i][1:0]);
      $display("strap case %0d done", i);
    end
    // Strap changes after loading must not disturb the defaults.
    lvl <= ~lvl;
    repeat (10) @(posedge pclk);
    check({27'h0, outs[4:0]}, 32'h07);
    apb(1'b1, `OFF_FLOW_CTRL, 32'h8);
    apb(1'b0, `OFF_FLOW_CTRL, 32'h0);
    check(rd, 32'h8);
    check({27'h0, outs[4:0]}, 32'h08);
    // An unmapped address is refused and reads zero.
    apb(1'b0, 12'h01c, 32'h0);
    check({rd[30:0], rerr}, 32'h1);
    $display("hold and software write test done");
    // Loader-supplied values replace the pins on a reload.
    apb(1'b1, `OFF_STRAP_CTRL, 32'h63);
    repeat (30) @(posedge pclk);
    check({27'h0, outs[4:0]}, 32'h07);
    // The loader values and the latched set must read back as written.
    apb(1'b0, `OFF_STRAP_CTRL, 32'h0);
    check(rd, 32'h23);
    apb(1'b0, `OFF_STRAP_STATUS, 32'h0);
    check(rd, 32'h03);
    apb(1'b0, `OFF_OVERRIDE, 32'h0);
    check(rd, {30'h0, MODE_RMII_PHY});
    $display("override test done");
    tally_and_finish();
  end
  // Cuts a hang short.
  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end
endmodule // port0_strap_defaults_bench
`default_nettype wire
